// file: ofd_decoder.sv
// module: operand-field decoder collecting operand bytes after an opcode
`timescale 1ns/1ps
`default_nettype none
module ofd_decoder (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    input  wire logic                   instr_start,
    input  wire ofd_pkg::ofd_fmt_t      instr_fmt,
    input  wire logic [7:0]             opcode,
    input  wire logic [15:0]            opcode_addr,
    input  wire logic                   byte_valid,
    input  wire logic [7:0]             byte_in,
    input  wire logic [7:0]             window_base_pointer,
    input  wire logic [7:0]             src_data,
    input  wire logic [7:0]             dst_data,
    output logic                        busy_reg,
    output logic                        dec_done_reg,
    output logic [11:0]                 src_addr_reg,
    output logic [11:0]                 dst_addr_reg,
    output logic [7:0]                  imm_val_reg,
    output logic [15:0]                 target_reg,
    output logic [7:0]                  vector_reg,
    output logic [2:0]                  bit_sel_reg,
    output logic                        polarity_reg,
    output logic                        pair_err_reg,
    output logic                        add_wr_en_reg,
    output logic [11:0]                 add_wr_addr_reg,
    output logic [7:0]                  add_wr_data_reg
);
    // ************************************************************
    // collection state
    // ************************************************************
    typedef enum logic {ST_IDLE, ST_COLLECT} ofd_state_t;

    ofd_state_t        state_reg;
    ofd_pkg::ofd_fmt_t fmt_reg;
    logic [7:0]        opc_reg;
    logic [15:0]       pc_reg;
    logic [7:0]        byte0_reg;
    logic              have0_reg;
    logic              is_add_reg;
    logic              two_bytes;
    logic              last_byte;
    logic [7:0]        first_b;
    logic [11:0]       first_addr;
    logic [11:0]       second_addr;
    logic              first_esc;
    logic              second_esc;
    logic [15:0]       next_pc;

    always_comb begin
        two_bytes = (fmt_reg == ofd_pkg::FMT_REG_REG) || (fmt_reg == ofd_pkg::FMT_ABS)
                 || (fmt_reg == ofd_pkg::FMT_LONG) || (fmt_reg == ofd_pkg::FMT_IDX);
    end

    assign last_byte = (state_reg == ST_COLLECT) && byte_valid && (have0_reg || !two_bytes);
    assign first_b   = have0_reg ? byte0_reg : byte_in;
    // next instruction starts after opcode plus operand bytes
    assign next_pc   = pc_reg + (two_bytes ? 16'h0003 : 16'h0002);

    ofd_work_reg_map u_first_map (
        .raw_field           (first_b),
        .window_base_pointer (window_base_pointer),
        .full_addr           (first_addr),
        .escaped             (first_esc)
    );

    ofd_work_reg_map u_second_map (
        .raw_field           (byte_in),
        .window_base_pointer (window_base_pointer),
        .full_addr           (second_addr),
        .escaped             (second_esc)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            fmt_reg   <= ofd_pkg::FMT_REG_REG;
            opc_reg   <= 8'h00;
            pc_reg    <= ofd_pkg::PC_RESET;
            byte0_reg <= 8'h00;
            have0_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else if (ce) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (instr_start) begin
                        state_reg <= ST_COLLECT;
                        fmt_reg   <= instr_fmt;
                        opc_reg   <= opcode;
                        pc_reg    <= opcode_addr;
                        have0_reg <= 1'b0;
                        busy_reg  <= 1'b1;
                    end
                end
                ST_COLLECT: begin
                    if (last_byte) begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end else if (byte_valid) begin
                        byte0_reg <= byte_in;
                        have0_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // field decode, registered on the last operand byte
    // ************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dec_done_reg <= 1'b0;
            src_addr_reg <= 12'h000;
            dst_addr_reg <= 12'h000;
            imm_val_reg  <= 8'h00;
            target_reg   <= 16'h0000;
            vector_reg   <= 8'h00;
            bit_sel_reg  <= 3'h0;
            polarity_reg <= 1'b0;
            pair_err_reg <= 1'b0;
            is_add_reg   <= 1'b0;
        end else if (ce) begin
            dec_done_reg <= last_byte;
            is_add_reg   <= 1'b0;
            if (last_byte) begin
                pair_err_reg <= 1'b0;
                unique case (fmt_reg)
                    ofd_pkg::FMT_REG_REG: begin
                        src_addr_reg <= first_addr;
                        dst_addr_reg <= second_addr;
                        is_add_reg   <= (opc_reg == ofd_pkg::ADD_OPCODE);
                    end
                    ofd_pkg::FMT_JUMP: begin
                        target_reg <= next_pc + {{8{byte_in[7]}}, byte_in};
                    end
                    ofd_pkg::FMT_ABS: begin
                        target_reg <= {first_b, byte_in};
                    end
                    ofd_pkg::FMT_IMM: begin
                        imm_val_reg <= byte_in;
                    end
                    ofd_pkg::FMT_VEC: begin
                        vector_reg <= byte_in;
                    end
                    ofd_pkg::FMT_LONG: begin
                        dst_addr_reg <= {first_b[3:0], byte_in};
                    end
                    ofd_pkg::FMT_BIT: begin
                        bit_sel_reg  <= byte_in[ofd_pkg::BIT_IDX_LSB +: ofd_pkg::BIT_IDX_W];
                        polarity_reg <= byte_in[ofd_pkg::POL_POS];
                    end
                    ofd_pkg::FMT_IDX: begin
                        // index wraps inside the 12-bit register space
                        dst_addr_reg <= first_addr + {{4{byte_in[7]}}, byte_in};
                    end
                    ofd_pkg::FMT_PAIR, ofd_pkg::FMT_WPAIR: begin
                        dst_addr_reg <= second_addr;
                        pair_err_reg <= byte_in[0];
                    end
                    ofd_pkg::FMT_IND: begin
                        dst_addr_reg <= second_addr;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // add write-back, one cycle after decode
    // ************************************************************
    // operand values must be presented while dec_done_reg is high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            add_wr_en_reg   <= 1'b0;
            add_wr_addr_reg <= 12'h000;
            add_wr_data_reg <= 8'h00;
        end else if (ce) begin
            add_wr_en_reg <= dec_done_reg && is_add_reg;
            if (dec_done_reg && is_add_reg) begin
                add_wr_addr_reg <= dst_addr_reg;
                add_wr_data_reg <= src_data + dst_data;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_src_first_byte: assert property (ce && last_byte
        && fmt_reg == ofd_pkg::FMT_REG_REG && have0_reg && !first_esc
        |=> src_addr_reg == {4'h0, $past(byte0_reg)})
        else $error("source address not from first operand byte");
    a_escaped_index: assert property (ce && last_byte
        && fmt_reg == ofd_pkg::FMT_IND && byte_in[7:4] == ofd_pkg::ESC_NIBBLE
        |=> dst_addr_reg[3:0] == $past(byte_in[3:0]))
        else $error("escaped working index lost");
    a_jump_target: assert property (ce && last_byte
        && fmt_reg == ofd_pkg::FMT_JUMP
        |=> target_reg == $past(pc_reg) + 16'h0002
            + {{8{$past(byte_in[7])}}, $past(byte_in)})
        else $error("relative target wrong");
    a_pair_odd_err: assert property (ce && last_byte
        && (fmt_reg == ofd_pkg::FMT_PAIR || fmt_reg == ofd_pkg::FMT_WPAIR)
        |=> pair_err_reg == $past(byte_in[0]))
        else $error("pair parity error flag wrong");
    a_long_addr: assert property (ce && last_byte
        && fmt_reg == ofd_pkg::FMT_LONG
        |=> dst_addr_reg == {$past(byte0_reg[3:0]), $past(byte_in)})
        else $error("long register address wrong");
    a_bit_polarity: assert property (ce && last_byte
        && fmt_reg == ofd_pkg::FMT_BIT
        |=> bit_sel_reg == $past(byte_in[6:4]) && polarity_reg == $past(byte_in[0]))
        else $error("bit index or polarity wrong");
    a_abs_target: assert property (ce && last_byte
        && fmt_reg == ofd_pkg::FMT_ABS
        |=> target_reg == {$past(byte0_reg), $past(byte_in)})
        else $error("absolute target wrong");
    // write enable is launched on the edge after decode, so it is seen two edges on
    a_add_writeback: assert property (ce && last_byte
        && fmt_reg == ofd_pkg::FMT_REG_REG && opc_reg == ofd_pkg::ADD_OPCODE
        ##1 ce |=> add_wr_en_reg && add_wr_addr_reg == $past(dst_addr_reg))
        else $error("add result not written to destination");
    a_done_one_cycle: assert property (ce && dec_done_reg ##1 ce |-> !dec_done_reg)
        else $error("decode done held too long");

    c_add_seen:   cover property (add_wr_en_reg);
    c_jump_back:  cover property (dec_done_reg && fmt_reg == ofd_pkg::FMT_JUMP
                                  && target_reg < pc_reg);
    c_pair_error: cover property (pair_err_reg && dec_done_reg);
    c_escaped:    cover property (ce && last_byte && second_esc);
endmodule : ofd_decoder
`default_nettype wire

// file: ofd_pkg.sv
// package: operand formats and field constants of the operand-field decoder
package ofd_pkg;
    // ************************************************************
    // operand formats, chosen by the opcode decoder upstream
    // ************************************************************
    typedef enum logic [3:0] {
        FMT_REG_REG,   // two 8-bit register fields, source byte first
        FMT_JUMP,      // signed relative displacement byte
        FMT_ABS,       // 16-bit absolute target, high byte first
        FMT_IMM,       // one immediate data byte
        FMT_VEC,       // trap vector byte
        FMT_LONG,      // 12-bit register address in two bytes
        FMT_BIT,       // bit index and polarity in one byte
        FMT_IDX,       // register field then signed index byte
        FMT_PAIR,      // register pair, direct or indirect
        FMT_WPAIR,     // working register pair, direct or indirect
        FMT_IND        // indirect register
    } ofd_fmt_t;

    // ************************************************************
    // field constants
    // ************************************************************
    localparam logic [7:0]  ADD_OPCODE   = 8'h04;
    localparam logic [3:0]  ESC_NIBBLE   = 4'hE;
    localparam int          BIT_IDX_LSB  = 4;
    localparam int          BIT_IDX_W    = 3;
    localparam int          POL_POS      = 0;
    localparam int          REG_ADDR_W   = 12;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam logic [7:0]  PTR_RESET    = 8'h00;
endpackage : ofd_pkg

// file: ofd_work_reg_map.sv
// module: maps an 8-bit register field onto the 12-bit register space
`timescale 1ns/1ps
`default_nettype none
module ofd_work_reg_map (
    input  wire logic [7:0]  raw_field,
    input  wire logic [7:0]  window_base_pointer,
    output logic      [11:0] full_addr,
    output logic             escaped
);
    // escaped field: pointer supplies the upper bits, field the 4-bit index
    always_comb begin
        escaped = (raw_field[7:4] == ofd_pkg::ESC_NIBBLE);
        if (escaped) begin
            full_addr = {window_base_pointer[3:0], window_base_pointer[7:4],
                         raw_field[3:0]};
        end else begin
            full_addr = {4'h0, raw_field};
        end
    end
endmodule : ofd_work_reg_map
`default_nettype wire

// file: ofd_fetch_model.sv
// fetch-path model: presents opcode and operand bytes from program memory
`timescale 1ns/1ps
`default_nettype none
module ofd_fetch_model (
    input  wire logic             clk,
    output logic                  instr_start,
    output var ofd_pkg::ofd_fmt_t instr_fmt,
    output logic [7:0]            opcode,
    output logic [15:0]           opcode_addr,
    output logic                  byte_valid,
    output logic [7:0]            byte_in
);
    initial begin
        instr_start = 1'b0;
        instr_fmt   = ofd_pkg::FMT_IMM;
        opcode      = 8'h00;
        opcode_addr = 16'h0000;
        byte_valid  = 1'b0;
        byte_in     = 8'h00;
    end

    // ************************************************************
    // one instruction: opcode edge, then one or two operand bytes
    // ************************************************************
    task automatic fetch(input ofd_pkg::ofd_fmt_t fmt, input logic [7:0] opc,
                         input logic [15:0] addr, input logic [7:0] b0,
                         input logic [7:0] b1, input logic two, input logic stall);
        @(posedge clk);
        instr_start <= 1'b1;
        instr_fmt   <= fmt;
        opcode      <= opc;
        opcode_addr <= addr;
        @(posedge clk);
        instr_start <= 1'b0;
        byte_valid  <= 1'b1;
        byte_in     <= b0;
        if (two) begin
            if (stall) begin
                // a stalled memory shows no stale byte
                @(posedge clk);
                byte_valid <= 1'b0;
                byte_in    <= ~b0;
            end
            @(posedge clk);
            byte_valid <= 1'b1;
            byte_in    <= b1;
        end
        @(posedge clk);
        byte_valid <= 1'b0;
        byte_in    <= two ? ~b1 : ~b0;
    endtask : fetch
endmodule : ofd_fetch_model
`default_nettype wire

// file: ofd_decoder_test.sv
// testbench: operand-field decoder driven by the fetch-path model
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) chk_val(16'(got), 16'(exp))
module ofd_decoder_test;
    logic clk, nrst, ce, instr_start, byte_valid, busy, done, perr, pol, wr_en;
    ofd_pkg::ofd_fmt_t fmt;
    logic [7:0]  opcode, byte_in, ptr, src_data, dst_data, imm, vec, wr_data;
    logic [15:0] opcode_addr, target;
    logic [11:0] src_addr, dst_addr, wr_addr;
    logic [2:0]  bit_sel;
    int          miscompares, samples_checked;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // register file stand-in: contents follow the address
    assign src_data = src_addr[7:0] ^ 8'hA5;
    assign dst_data = dst_addr[7:0] + 8'h11;

    ofd_fetch_model m (.clk(clk), .instr_start(instr_start), .instr_fmt(fmt),
        .opcode(opcode), .opcode_addr(opcode_addr), .byte_valid(byte_valid),
        .byte_in(byte_in));
    ofd_decoder dut (.clk(clk), .nrst(nrst), .ce(ce), .instr_start(instr_start),
        .instr_fmt(fmt), .opcode(opcode), .opcode_addr(opcode_addr),
        .byte_valid(byte_valid), .byte_in(byte_in), .window_base_pointer(ptr),
        .src_data(src_data), .dst_data(dst_data), .busy_reg(busy),
        .dec_done_reg(done), .src_addr_reg(src_addr), .dst_addr_reg(dst_addr),
        .imm_val_reg(imm), .target_reg(target), .vector_reg(vec),
        .bit_sel_reg(bit_sel), .polarity_reg(pol), .pair_err_reg(perr),
        .add_wr_en_reg(wr_en), .add_wr_addr_reg(wr_addr), .add_wr_data_reg(wr_data));

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // fetch one instruction, then stop at the settled done cycle
    task automatic run(input ofd_pkg::ofd_fmt_t f, input logic [7:0] opc,
                       input logic [15:0] a, input logic [7:0] b0, input logic [7:0] b1,
                       input logic two, input logic stall);
        m.fetch(f, opc, a, b0, b1, two, stall);
        for (int i = 0; i < 4 && done !== 1'b1; i++) @(negedge clk);
        `CHK(done, 1'b1);
        `CHK(busy, 1'b0);
    endtask : run

    task automatic t_add;
        @(posedge clk);
        ptr <= 8'h35;
        run(ofd_pkg::FMT_REG_REG, ofd_pkg::ADD_OPCODE, 16'h0100, 8'hE8, 8'h43, 1, 1);
        `CHK(src_addr, 12'h538);
        `CHK(dst_addr, 12'h043);
        @(negedge clk);
        `CHK(wr_en, 1'b1);
        `CHK(wr_addr, 12'h043);
        `CHK(wr_data, 8'(8'h38 ^ 8'hA5) + 8'h54);
        @(negedge clk);
        `CHK(wr_en, 1'b0);
        @(posedge clk);
        ptr <= 8'hC2;
        run(ofd_pkg::FMT_REG_REG, 8'h05, 16'h0200, 8'hFF, 8'hE0, 1, 0);
        `CHK(src_addr, 12'h0FF);
        `CHK(dst_addr, 12'h2C0);
        @(negedge clk);
        `CHK(wr_en, 1'b0);
        $display("test add done");
    endtask : t_add

    task automatic t_jump;
        logic [7:0] d [2] = '{8'h80, 8'h7F};
        for (int i = 0; i < 2; i++) begin
            run(ofd_pkg::FMT_JUMP, 8'h8B, 16'h1000, d[i], 8'h00, 0, 0);
            `CHK(target, 16'h1002 + {{8{d[i][7]}}, d[i]});
        end
        run(ofd_pkg::FMT_ABS, 8'h8D, 16'h1000, 8'h12, 8'h34, 1, 0);
        `CHK(target, 16'h1234);
        run(ofd_pkg::FMT_ABS, 8'h8D, 16'h1000, 8'hFF, 8'hFF, 1, 1);
        `CHK(target, 16'hFFFF);
        $display("test jump done");
    endtask : t_jump

    task automatic t_fields;
        run(ofd_pkg::FMT_LONG, 8'hE8, 16'h0000, 8'h0A, 8'hBC, 1, 0);
        `CHK(dst_addr, 12'hABC);
        run(ofd_pkg::FMT_BIT, 8'hE2, 16'h0000, 8'h71, 8'h00, 0, 0);
        `CHK(bit_sel, 3'h7);
        `CHK(pol, 1'b1);
        run(ofd_pkg::FMT_BIT, 8'hE2, 16'h0000, 8'h00, 8'h00, 0, 0);
        `CHK(bit_sel, 3'h0);
        `CHK(pol, 1'b0);
        run(ofd_pkg::FMT_IMM, 8'h0C, 16'h0000, 8'hFF, 8'h00, 0, 0);
        `CHK(imm, 8'hFF);
        run(ofd_pkg::FMT_VEC, 8'hF2, 16'h0000, 8'hFF, 8'h00, 0, 0);
        `CHK(vec, 8'hFF);
        run(ofd_pkg::FMT_IND, 8'h31, 16'h0000, 8'hFF, 8'h00, 0, 0);
        `CHK(dst_addr, 12'h0FF);
        // pointer still C2h: escaped indirect lands in the pointer's window
        run(ofd_pkg::FMT_IND, 8'h31, 16'h0000, 8'hE5, 8'h00, 0, 0);
        `CHK(dst_addr, 12'h2C5);
        run(ofd_pkg::FMT_IDX, 8'h98, 16'h0000, 8'h10, 8'h80, 1, 0);
        `CHK(dst_addr, 12'hF90);
        $display("test fields done");
    endtask : t_fields

    // clock enable low: a whole instruction must leave no trace
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        m.fetch(ofd_pkg::FMT_IMM, 8'h0C, 16'h0000, 8'h5A, 8'h00, 0, 0);
        @(negedge clk);
        `CHK(busy, 1'b0);
        `CHK(done, 1'b0);
        `CHK(imm, 8'hFF);
        @(posedge clk);
        ce <= 1'b1;
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_pairs;
        @(posedge clk);
        ptr <= 8'h35;
        run(ofd_pkg::FMT_PAIR, 8'hA0, 16'h0000, 8'hFE, 8'h00, 0, 0);
        `CHK(perr, 1'b0);
        `CHK(dst_addr, 12'h0FE);
        run(ofd_pkg::FMT_PAIR, 8'hA0, 16'h0000, 8'h03, 8'h00, 0, 0);
        `CHK(perr, 1'b1);
        run(ofd_pkg::FMT_WPAIR, 8'hA0, 16'h0000, 8'hEE, 8'h00, 0, 0);
        `CHK(perr, 1'b0);
        `CHK(dst_addr, 12'h53E);
        run(ofd_pkg::FMT_WPAIR, 8'hA0, 16'h0000, 8'hE7, 8'h00, 0, 0);
        `CHK(perr, 1'b1);
        $display("test pairs done");
    endtask : t_pairs

    task automatic end_of_test;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        #20000;
        miscompares++;
        end_of_test();
    end

    initial begin
        miscompares     = 0;
        samples_checked = 0;
        nrst = 1'b0;
        ce   = 1'b1;
        ptr  = 8'h00;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_add();
        t_jump();
        t_fields();
        t_freeze();
        t_pairs();
        end_of_test();
    end
endmodule : ofd_decoder_test
`default_nettype wire
